/* File: design/conditional_branch_unit.sv */
// Branch resolution for short conditional jumps and the unconditional jump
`timescale 1ns/1ps
module conditional_branch_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reqValid,
  output logic reqReady,
  input wire branch_pkg::cond_t reqCond,
  input wire branch_pkg::jform_t reqForm,
  input wire logic [branch_pkg::WORD_W-1:0] nextIp,
  input wire logic [branch_pkg::DISP_W-1:0] shortDisp,
  input wire logic [branch_pkg::WORD_W-1:0] nearDisp,
  input wire logic [branch_pkg::WORD_W-1:0] absTarget,
  input wire logic [branch_pkg::WORD_W-1:0] farSelector,
  input wire logic [branch_pkg::WORD_W-1:0] farOffset,
  input wire logic [branch_pkg::WORD_W-1:0] countReg,
  input wire logic [branch_pkg::FLAGS_W-1:0] flagsIn,
  input wire logic [branch_pkg::WORD_W-1:0] codeSeg,
  output logic doneValid,
  output logic branchTaken,
  output logic [branch_pkg::WORD_W-1:0] newIp,
  output logic [branch_pkg::WORD_W-1:0] newCs,
  output logic csLoad,
  output logic [branch_pkg::FLAGS_W-1:0] flagsOut
);
  import branch_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic {
    ST_IDLE,
    ST_EVAL
  } state_t;

  state_t state_ff;
  state_t nxt_state;
  cond_t cond_ff;
  jform_t form_ff;
  logic [WORD_W-1:0] nextIp_ff;
  logic [DISP_W-1:0] disp_ff;
  logic [WORD_W-1:0] nearDisp_ff;
  logic [WORD_W-1:0] absTarget_ff;
  logic [WORD_W-1:0] farSel_ff;
  logic [WORD_W-1:0] farOff_ff;
  logic [WORD_W-1:0] count_ff;
  logic [FLAGS_W-1:0] flags_ff;
  logic [WORD_W-1:0] codeSeg_ff;
  logic doneValid_ff;
  logic taken_ff;
  logic [WORD_W-1:0] newIp_ff;
  logic [WORD_W-1:0] newCs_ff;
  logic csLoad_ff;
  logic [FLAGS_W-1:0] flagsOut_ff;

  // ****************************************
  // Handshake decode
  // ****************************************
  wire logic accept = reqValid && reqReady;
  wire logic evaluating = (state_ff == ST_EVAL);

  assign reqReady = (state_ff == ST_IDLE);
  assign nxt_state = accept ? ST_EVAL : ST_IDLE;

  // ****************************************
  // Condition evaluator
  // ****************************************
  cond_if cif ();

  assign cif.op = cond_ff;
  assign cif.flags = flags_ff;
  assign cif.count = count_ff;

  branch_cond_eval u_eval (
    .cif(cif)
  );

  // ****************************************
  // Target arithmetic
  // ****************************************
  // Wraps modulo 64K, as the pointer does within a segment
  wire logic [WORD_W-1:0] sextDisp = {{(WORD_W-DISP_W){disp_ff[DISP_W-1]}}, disp_ff};
  wire logic [WORD_W-1:0] shortTarget = nextIp_ff + sextDisp;
  wire logic [WORD_W-1:0] nearTarget = nextIp_ff + nearDisp_ff;
  wire logic isAlways = (cond_ff == CND_ALWAYS);
  wire logic isFar = (form_ff == FORM_FAR) || (form_ff == FORM_MEM_FAR);
  wire logic isShortForm = (form_ff == FORM_SHORT);
  wire logic isNearForm = (form_ff == FORM_NEAR);

  // Register and memory-pointer near forms carry an absolute offset
  wire logic [WORD_W-1:0] alwaysTarget = isFar ? farOff_ff :
                                         isShortForm ? shortTarget :
                                         isNearForm ? nearTarget : absTarget_ff;
  wire logic [WORD_W-1:0] condTarget = cif.taken ? shortTarget : nextIp_ff;
  wire logic [WORD_W-1:0] resolvedIp = isAlways ? alwaysTarget : condTarget;
  wire logic loadSegment = isAlways && isFar;
  wire logic [WORD_W-1:0] resolvedCs = loadSegment ? farSel_ff : codeSeg_ff;

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Operands are frozen at acceptance so the caller may move on at once
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cond_ff <= CND_ALWAYS;
      form_ff <= FORM_SHORT;
      nextIp_ff <= WORD_RESET;
      disp_ff <= '0;
      nearDisp_ff <= WORD_RESET;
      absTarget_ff <= WORD_RESET;
    end
    else if (accept)
    begin
      cond_ff <= reqCond;
      form_ff <= reqForm;
      nextIp_ff <= nextIp;
      disp_ff <= shortDisp;
      nearDisp_ff <= nearDisp;
      absTarget_ff <= absTarget;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      farSel_ff <= WORD_RESET;
      farOff_ff <= WORD_RESET;
      count_ff <= WORD_RESET;
      flags_ff <= FLAGS_RESET;
      codeSeg_ff <= WORD_RESET;
    end
    else if (accept)
    begin
      farSel_ff <= farSelector;
      farOff_ff <= farOffset;
      count_ff <= countReg;
      flags_ff <= flagsIn;
      codeSeg_ff <= codeSeg;
    end
  end

  // ****************************************
  // Result registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      doneValid_ff <= 1'b0;
    else
      doneValid_ff <= evaluating;
  end

  // Results hold their value until the next resolution
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      taken_ff <= 1'b0;
      newIp_ff <= WORD_RESET;
      newCs_ff <= WORD_RESET;
      csLoad_ff <= 1'b0;
      flagsOut_ff <= FLAGS_RESET;
    end
    else if (evaluating)
    begin
      taken_ff <= cif.taken;
      newIp_ff <= resolvedIp;
      newCs_ff <= resolvedCs;
      csLoad_ff <= loadSegment;
      flagsOut_ff <= flags_ff;
    end
  end

  assign doneValid = doneValid_ff;
  assign branchTaken = taken_ff;
  assign newIp = newIp_ff;
  assign newCs = newCs_ff;
  assign csLoad = csLoad_ff;
  assign flagsOut = flagsOut_ff;

  // ****************************************
  // Checks
  // ****************************************
  wire logic inZero = flagsIn[ZERO_BIT];
  wire logic inSign = flagsIn[SIGN_BIT];
  wire logic inOver = flagsIn[OVERFLOW_BIT];
  wire logic inCarry = flagsIn[CARRY_BIT];
  wire logic inParity = flagsIn[PARITY_BIT];
  wire logic reqFar = (reqForm == FORM_FAR) || (reqForm == FORM_MEM_FAR);
  wire logic [WORD_W-1:0] reqShortTarget = nextIp + {{(WORD_W-DISP_W){shortDisp[DISP_W-1]}}, shortDisp};

  a_count_zero: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_COUNT_ZERO |-> ##2 doneValid && branchTaken == ($past(countReg, 2) == COUNT_ZERO))
    else $error("count-zero jump decided wrongly");

  a_short_target: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond != CND_ALWAYS |-> ##2 !branchTaken || newIp == $past(reqShortTarget, 2))
    else $error("short jump target is not pointer plus displacement");

  a_equal_cond: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_EQUAL |-> ##2 branchTaken == $past(inZero, 2))
    else $error("equal jump decided wrongly");

  a_greater_cond: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_GREATER |->
      ##2 branchTaken == (($past(inSign, 2) == $past(inOver, 2)) && !$past(inZero, 2)))
    else $error("greater jump decided wrongly");

  a_greater_eq_cond: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_GREATER_EQ |->
      ##2 branchTaken == ($past(inSign, 2) == $past(inOver, 2)))
    else $error("greater-or-equal jump decided wrongly");

  a_less_cond: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_LESS |->
      ##2 branchTaken == ($past(inSign, 2) != $past(inOver, 2)))
    else $error("less jump decided wrongly");

  a_less_eq_cond: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_LESS_EQ |->
      ##2 branchTaken == (($past(inSign, 2) != $past(inOver, 2)) || $past(inZero, 2)))
    else $error("less-or-equal jump decided wrongly");

  a_always_taken: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_ALWAYS && reqFar |->
      ##2 branchTaken && csLoad && newCs == $past(farSelector, 2) && newIp == $past(farOffset, 2))
    else $error("far jump did not load selector and offset");

  a_no_carry_cond: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_NO_CARRY |-> ##2 branchTaken == !$past(inCarry, 2))
    else $error("no-carry jump decided wrongly");

  a_not_equal_cond: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_NOT_EQUAL |-> ##2 branchTaken == !$past(inZero, 2))
    else $error("not-equal jump decided wrongly");

  a_no_overflow_cond: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_NO_OVERFLOW |-> ##2 branchTaken == !$past(inOver, 2))
    else $error("no-overflow jump decided wrongly");

  a_no_sign_cond: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_NO_SIGN |-> ##2 branchTaken == !$past(inSign, 2))
    else $error("no-sign jump decided wrongly");

  a_parity_clear_cond: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_PARITY_CLEAR |-> ##2 branchTaken == !$past(inParity, 2))
    else $error("parity-clear jump decided wrongly");

  a_flags_untouched: assert property (@(posedge clk) disable iff (!rst_n)
    accept |-> ##2 doneValid && flagsOut == $past(flagsIn, 2))
    else $error("jump altered the flag word");

  a_fall_through: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond != CND_ALWAYS |-> ##2 branchTaken || (newIp == $past(nextIp, 2) && !csLoad))
    else $error("untaken jump did not fall through");

  a_intra_segment: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond == CND_ALWAYS && !reqFar |-> ##2 !csLoad && newCs == $past(codeSeg, 2))
    else $error("intra-segment jump changed the code segment");

  a_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    doneValid |-> $past(evaluating) ##1 !doneValid)
    else $error("completion is not a single-cycle pulse");

  a_busy_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    accept |=> !reqReady ##1 reqReady)
    else $error("unit took no single busy cycle after a request");

  // Results must stand between completions so the fetch path may read them late
  a_results_held: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && !doneValid |->
      $stable(newIp) && $stable(newCs) && $stable(csLoad) && $stable(branchTaken) && $stable(flagsOut))
    else $error("results changed without a completion");

  a_cond_segment: assert property (@(posedge clk) disable iff (!rst_n)
    accept && reqCond != CND_ALWAYS |-> ##2 !csLoad && newCs == $past(codeSeg, 2))
    else $error("conditional jump touched the code segment");

endmodule

/* File: design/branch_pkg.sv */
// Shared constants and types of the conditional branch unit
package branch_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int WORD_W = 16;
  localparam int DISP_W = 8;
  localparam int FLAGS_W = 16;

  // ****************************************
  // Flag word bit positions
  // ****************************************
  localparam int CARRY_BIT = 0;
  localparam int PARITY_BIT = 2;
  localparam int ZERO_BIT = 6;
  localparam int SIGN_BIT = 7;
  localparam int OVERFLOW_BIT = 11;

  // ****************************************
  // Values
  // ****************************************
  localparam logic [WORD_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [FLAGS_W-1:0] FLAGS_RESET = 16'h0000;

  // ****************************************
  // Conditions and jump forms
  // ****************************************
  typedef enum logic [3:0] {
    CND_COUNT_ZERO,
    CND_EQUAL,
    CND_GREATER,
    CND_GREATER_EQ,
    CND_LESS,
    CND_LESS_EQ,
    CND_NO_CARRY,
    CND_NOT_EQUAL,
    CND_NO_OVERFLOW,
    CND_NO_SIGN,
    CND_PARITY_CLEAR,
    CND_ALWAYS
  } cond_t;

  typedef enum logic [2:0] {
    FORM_SHORT,
    FORM_NEAR,
    FORM_FAR,
    FORM_MEM_NEAR,
    FORM_MEM_FAR,
    FORM_REG
  } jform_t;

endpackage

/* File: design/cond_if.sv */
// Condition request and verdict between the branch unit and its evaluator
`timescale 1ns/1ps
interface cond_if;
  import branch_pkg::*;
  cond_t op;
  logic [FLAGS_W-1:0] flags;
  logic [WORD_W-1:0] count;
  logic taken;

  modport evaluator (
    input op,
    input flags,
    input count,
    output taken
  );

  modport requester (
    output op,
    output flags,
    output count,
    input taken
  );
endinterface

/* File: design/branch_cond_eval.sv */
// Combinational evaluation of the branch conditions
`timescale 1ns/1ps
module branch_cond_eval (
  cond_if.evaluator cif
);
  import branch_pkg::*;

  wire logic carryFlag = cif.flags[CARRY_BIT];
  wire logic parityFlag = cif.flags[PARITY_BIT];
  wire logic zeroFlag = cif.flags[ZERO_BIT];
  wire logic signFlag = cif.flags[SIGN_BIT];
  wire logic overflowFlag = cif.flags[OVERFLOW_BIT];
  wire logic signMatch = (signFlag == overflowFlag);
  wire logic countIsZero = (cif.count == COUNT_ZERO);

  always_comb
  begin
    unique case (cif.op)
      CND_COUNT_ZERO: cif.taken = countIsZero;
      CND_EQUAL: cif.taken = zeroFlag;
      CND_GREATER: cif.taken = signMatch && !zeroFlag;
      CND_GREATER_EQ: cif.taken = signMatch;
      CND_LESS: cif.taken = !signMatch;
      CND_LESS_EQ: cif.taken = !signMatch || zeroFlag;
      CND_NO_CARRY: cif.taken = !carryFlag;
      CND_NOT_EQUAL: cif.taken = !zeroFlag;
      CND_NO_OVERFLOW: cif.taken = !overflowFlag;
      CND_NO_SIGN: cif.taken = !signFlag;
      CND_PARITY_CLEAR: cif.taken = !parityFlag;
      CND_ALWAYS: cif.taken = 1'b1;
      default: cif.taken = 1'b0;
    endcase
  end
endmodule

/* File: testbench/conditional_branch_unit_test.sv */
// Self-checking testbench of the conditional branch unit
`timescale 1ns/1ps
module conditional_branch_unit_test;
  import branch_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic clk, rst_n, reqValid, reqReady, doneValid, branchTaken, csLoad;
  cond_t reqCond;
  jform_t reqForm;
  logic [DISP_W-1:0] shortDisp;
  logic [WORD_W-1:0] nextIp, nearDisp, absTarget, farSelector, farOffset, countReg, codeSeg, newIp, newCs;
  logic [FLAGS_W-1:0] flagsIn, flagsOut;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;

  conditional_branch_unit u_conditional_branch_unit (
    .clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady), .reqCond(reqCond),
    .reqForm(reqForm), .nextIp(nextIp), .shortDisp(shortDisp), .nearDisp(nearDisp),
    .absTarget(absTarget), .farSelector(farSelector), .farOffset(farOffset), .countReg(countReg),
    .flagsIn(flagsIn), .codeSeg(codeSeg), .doneValid(doneValid), .branchTaken(branchTaken),
    .newIp(newIp), .newCs(newCs), .csLoad(csLoad), .flagsOut(flagsOut)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Run is about 1600 cycles; the ceiling leaves ample margin
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      n_fail++;
      $display("TIMEOUT after %0d cycles", cycles);
      finish_test();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask

  function automatic logic [WORD_W-1:0] sx(input logic [DISP_W-1:0] d);
    return {{(WORD_W-DISP_W){d[DISP_W-1]}}, d};
  endfunction

  // Reference verdict worked out independently from the flag word
  function automatic logic exp_tk(input cond_t c, input logic [FLAGS_W-1:0] f, input logic [WORD_W-1:0] cnt);
    logic z, s, o;
    z = f[ZERO_BIT];
    s = f[SIGN_BIT];
    o = f[OVERFLOW_BIT];
    case (c)
      CND_COUNT_ZERO: return cnt == 16'h0000;
      CND_EQUAL: return z;
      CND_GREATER: return (s == o) && !z;
      CND_GREATER_EQ: return s == o;
      CND_LESS: return s != o;
      CND_LESS_EQ: return (s != o) || z;
      CND_NO_CARRY: return !f[CARRY_BIT];
      CND_NOT_EQUAL: return !z;
      CND_NO_OVERFLOW: return !o;
      CND_NO_SIGN: return !s;
      CND_PARITY_CLEAR: return !f[PARITY_BIT];
      CND_ALWAYS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Reset is entered and left just after a rising edge
  task automatic do_reset(input int n);
    rst_n = 1'b0;
    repeat (n) @(posedge clk);
    #1;
    chk("reqReady", 1, reqReady);
    chk("doneValid", 0, doneValid);
    chk("branchTaken", 0, branchTaken);
    chk("newIp", 16'h0000, newIp);
    chk("newCs", 16'h0000, newCs);
    chk("csLoad", 0, csLoad);
    chk("flagsOut", 16'h0000, flagsOut);
    rst_n = 1'b1;
    @(posedge clk);
    #1;
  endtask

  // One request, entered just after an edge; other inputs set by the caller
  task automatic run(input cond_t c, input jform_t f, input logic [FLAGS_W-1:0] flg,
                     input logic [WORD_W-1:0] cnt, input logic expTk, input logic [WORD_W-1:0] expIp,
                     input logic expLoad, input logic [WORD_W-1:0] expCs);
    reqCond = c;
    reqForm = f;
    flagsIn = flg;
    countReg = cnt;
    reqValid = 1'b1;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    chk("reqReady busy", 0, reqReady);
    @(posedge clk);
    #1;
    chk("doneValid", 1, doneValid);
    chk("branchTaken", expTk, branchTaken);
    chk("newIp", expIp, newIp);
    chk("csLoad", expLoad, csLoad);
    chk("newCs", expCs, newCs);
    chk("flagsOut", flg, flagsOut);
    @(posedge clk);
    #1;
    chk("doneValid pulse", 0, doneValid);
    chk("newIp held", expIp, newIp);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_count_zero();
    logic [WORD_W-1:0] cnts [4] = '{16'h0000, 16'h0001, 16'h8000, 16'hFFFF};
    nextIp = 16'h0040;
    shortDisp = 8'h80;
    foreach (cnts[i])
      run(CND_COUNT_ZERO, FORM_SHORT, 16'h0040, cnts[i], cnts[i] == 0,
          cnts[i] == 0 ? 16'hFFC0 : 16'h0040, 0, codeSeg);
    $display("test count_zero done");
  endtask

  task automatic test_flag_conds();
    logic [FLAGS_W-1:0] flg;
    logic tk;
    for (int c = 0; c < 16; c++)
      for (int m = 0; m < 32; m++)
      begin
        flg = 16'h0700;
        flg[CARRY_BIT] = m[0];
        flg[PARITY_BIT] = m[1];
        flg[ZERO_BIT] = m[2];
        flg[SIGN_BIT] = m[3];
        flg[OVERFLOW_BIT] = m[4];
        nextIp = 16'hFFF0 + 16'(m);
        shortDisp = m[0] ? 8'h7F : 8'h81;
        tk = exp_tk(cond_t'(c), flg, 16'h0001);
        run(cond_t'(c), FORM_SHORT, flg, 16'h0001, tk, tk ? nextIp + sx(shortDisp) : nextIp,
            0, codeSeg);
      end
    $display("test flag_conds done");
  endtask

  task automatic test_always_forms();
    jform_t f;
    logic [WORD_W-1:0] ip;
    logic far;
    nextIp = 16'h2000;
    shortDisp = 8'hF0;
    nearDisp = 16'h8001;
    absTarget = 16'h5A5A;
    farSelector = 16'h3C3C;
    farOffset = 16'h0FF0;
    for (int i = 0; i < 6; i++)
    begin
      f = jform_t'(i);
      far = (f == FORM_FAR) || (f == FORM_MEM_FAR);
      case (f)
        FORM_SHORT: ip = 16'h1FF0;
        FORM_NEAR: ip = 16'hA001;
        FORM_MEM_NEAR, FORM_REG: ip = 16'h5A5A;
        default: ip = 16'h0FF0;
      endcase
      run(CND_ALWAYS, f, 16'hFFFF, 16'h0005, 1, ip, far, far ? 16'h3C3C : codeSeg);
    end
    $display("test always_forms done");
  endtask

  // A request held through the busy cycle must be taken once, after the result
  task automatic test_back_to_back();
    nextIp = 16'h0100;
    shortDisp = 8'h10;
    reqCond = CND_EQUAL;
    flagsIn = 16'h0040;
    reqValid = 1'b1;
    @(posedge clk);
    #1;
    reqCond = CND_NOT_EQUAL;
    nextIp = 16'h0200;
    chk("reqReady busy", 0, reqReady);
    @(posedge clk);
    #1;
    chk("doneValid a", 1, doneValid);
    chk("branchTaken a", 1, branchTaken);
    chk("newIp a", 16'h0110, newIp);
    chk("reqReady", 1, reqReady);
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    chk("doneValid gap", 0, doneValid);
    @(posedge clk);
    #1;
    chk("doneValid b", 1, doneValid);
    chk("branchTaken b", 0, branchTaken);
    chk("newIp b", 16'h0200, newIp);
    @(posedge clk);
    #1;
    chk("doneValid once", 0, doneValid);
    $display("test back_to_back done");
  endtask

  // Reset lands while a request is being evaluated; the unit must drop it and serve at once
  task automatic test_mid_reset();
    nextIp = 16'h0300;
    shortDisp = 8'hFE;
    reqCond = CND_EQUAL;
    flagsIn = 16'h0040;
    reqValid = 1'b1;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    do_reset(2);
    run(CND_NO_SIGN, FORM_SHORT, 16'h0000, 16'h0000, 1, 16'h02FE, 0, codeSeg);
    $display("test mid_reset done");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    reqCond = CND_EQUAL;
    reqForm = FORM_SHORT;
    nextIp = 16'h0000;
    shortDisp = 8'h00;
    nearDisp = 16'h0000;
    absTarget = 16'h0000;
    farSelector = 16'h0000;
    farOffset = 16'h0000;
    countReg = 16'h0000;
    flagsIn = 16'h0000;
    codeSeg = 16'h1234;
    #1;
    do_reset(5);
    $display("test reset done");
    test_count_zero();
    test_flag_conds();
    test_always_forms();
    test_back_to_back();
    test_mid_reset();
    finish_test();
  end
endmodule
